// ==== hw/ptpc_pkg.sv ====
package ptpc_pkg;

  // counter widths of the two timer instances
  localparam int PTPC_W0 = 16;
  localparam int PTPC_W1 = 10;
  localparam int PTPC_NTMR = 2;

  // register offsets inside one instance window
  localparam logic [2:0] PTPC_REG_CTRL = 3'h0;
  localparam logic [2:0] PTPC_REG_CMPA = 3'h1;
  localparam logic [2:0] PTPC_REG_CMPB = 3'h2;
  localparam logic [2:0] PTPC_REG_PER = 3'h3;
  localparam logic [2:0] PTPC_REG_CNT = 3'h4;
  localparam logic [2:0] PTPC_REG_STAT = 3'h5;
  localparam logic [7:0] PTPC_INST_STRIDE = 8'h20;
  localparam logic [7:0] PTPC_MAP_SIZE = 8'h40;

  // control register field positions
  localparam int PTPC_C_RUN = 0;
  localparam int PTPC_C_MODE = 1;
  localparam int PTPC_C_IO = 3;
  localparam int PTPC_C_CCLR = 5;
  localparam int PTPC_C_CAPTS = 6;
  localparam int PTPC_C_TCLR = 7;
  localparam int PTPC_C_OC = 9;
  localparam int PTPC_C_POL = 10;

  // status register field positions
  localparam int PTPC_S_MATCH_A = 0;
  localparam int PTPC_S_MATCH_P = 1;
  localparam int PTPC_S_CAPTURE = 2;
  localparam int PTPC_S_VLF = 3;

  // mode field codes
  localparam logic [1:0] PTPC_MODE_CMP = 2'h0;
  localparam logic [1:0] PTPC_MODE_CAP = 2'h1;
  localparam logic [1:0] PTPC_MODE_PWM = 2'h2;
  localparam logic [1:0] PTPC_MODE_TMR = 2'h3;

  // output action field codes
  localparam logic [1:0] PTPC_IO_LOW = 2'h0;
  localparam logic [1:0] PTPC_IO_HIGH = 2'h1;
  localparam logic [1:0] PTPC_IO_PWM = 2'h2;
  localparam logic [1:0] PTPC_IO_PULSE = 2'h3;

  // capture edge codes share the output action field
  localparam logic [1:0] PTPC_EDGE_RISE = 2'h0;
  localparam logic [1:0] PTPC_EDGE_FALL = 2'h1;
  localparam logic [1:0] PTPC_EDGE_BOTH = 2'h2;
  localparam logic [1:0] PTPC_EDGE_NONE = 2'h3;

  // capture counter clear codes
  localparam logic [1:0] PTPC_TCLR_PER = 2'h0;
  localparam logic [1:0] PTPC_TCLR_RISE = 2'h1;
  localparam logic [1:0] PTPC_TCLR_FALL = 2'h2;
  localparam logic [1:0] PTPC_TCLR_BOTH = 2'h3;

  // reset value and bus transfer code
  localparam logic [15:0] PTPC_RST_VAL = 16'h0000;
  localparam logic [1:0] PTPC_HTRANS_NONSEQ = 2'h2;

  // per-timer state
  typedef struct packed {
    logic        run;
    logic        run_prev;
    logic [1:0]  mode;
    logic [1:0]  io;
    logic        cclr;
    logic        capts;
    logic [1:0]  tclr;
    logic        oc;
    logic        pol;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] per;
    logic [15:0] cnt;
    logic        flag_a;
    logic        flag_p;
    logic        flag_cap;
    logic        vlf;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        cap_s1;
    logic        cap_s2;
    logic        cap_prev;
    logic        pin;
    logic        pin_en;
  } ptpc_tmr_t;

  // whole block state
  typedef struct packed {
    ptpc_tmr_t [1:0] tmr;
    logic            wr_pend;
    logic [5:0]      wr_addr;
    logic [31:0]     rdata;
    logic            ready;
    logic            resp;
  } ptpc_state_t;

endpackage

// ==== hw/ptpc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - mode 10 with action 10 is PWM
// - 16-bit period 1..65535, zero gives 65536
// - 10-bit period 1..1023, zero gives 1024
// - period match clears counter; A sets duty
// - duty at or above period gives 100%
// - PWM counts on when action is 00/01
// - single pulse is mode 10, action 11
// - clock pin edge sets run bit
// - run rise starts counter and pulse
// - A match or software clear ends pulse
// - single pulse clears only at run rise
// - mode 01 captures; source select picks pin
// - edge select rise/fall/both; 11 disables
// - capture counter into A or B, flag
// - capture counter free-runs while run high
// - period match clears counter, flags; zero=max
// - clear field adds rise/fall/both clears
// - edge field picks captures; clear field not 00 sends fall captures to B
// - pulses under two clocks may vanish
// - clear field 00 ignores latch flag
// - capture ignores cclr, oc and pol
// - capture pins sampled even when driven
module ptpc_timer
  import ptpc_pkg::*;
#(
  parameter int W0 = ptpc_pkg::PTPC_W0,
  parameter int W1 = ptpc_pkg::PTPC_W1
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [1:0]  ext_clk_pin,
  input  wire logic [1:0]  capture_pin,
  output logic [1:0]       timer_out,
  output logic [1:0]       timer_out_en
);

  import ptpc_pkg::*;

  localparam logic [15:0] MASK0 = 16'((32'h1 << W0) - 32'h1);
  localparam logic [15:0] MASK1 = 16'((32'h1 << W1) - 32'h1);

  ptpc_state_t st;
  ptpc_state_t nx;
  ptpc_tmr_t   cur;
  ptpc_tmr_t   t;
  logic [15:0] msk;
  logic [16:0] peff;
  logic        pmatch;
  logic        amatch;
  logic        rise;
  logic        ext_rise;
  logic        src;
  logic        src_prev;
  logic        src_rise;
  logic        src_fall;
  logic        cap_ev;
  logic        clr;
  logic        active;
  logic        sel;
  logic [7:0]  ra;
  logic [31:0] rd;

  // next state: bus access, then per-timer counting and events
  always_comb
  begin
    nx = st;
    cur = '0;
    t = '0;
    msk = MASK0;
    peff = '0;
    pmatch = 1'b0;
    amatch = 1'b0;
    rise = 1'b0;
    ext_rise = 1'b0;
    src = 1'b0;
    src_prev = 1'b0;
    src_rise = 1'b0;
    src_fall = 1'b0;
    cap_ev = 1'b0;
    clr = 1'b0;
    active = 1'b0;
    ra = haddr[7:0];
    rd = 32'h0;
    sel = hsel & hready & (htrans == PTPC_HTRANS_NONSEQ);
    nx.ready = 1'b1;
    nx.resp = 1'b0;

    for (int i = 0; i < PTPC_NTMR; i++)
    begin
      cur = st.tmr[i];
      t = cur;
      msk = (i == 0) ? MASK0 : MASK1;

      // software write from the previous address phase
      if (st.wr_pend && (st.wr_addr[5] == i[0]))
      begin
        case (st.wr_addr[4:2])
          PTPC_REG_CTRL:
          begin
            t.run = hwdata[PTPC_C_RUN];
            t.mode = hwdata[PTPC_C_MODE +: 2];
            t.io = hwdata[PTPC_C_IO +: 2];
            t.cclr = hwdata[PTPC_C_CCLR];
            t.capts = hwdata[PTPC_C_CAPTS];
            t.tclr = hwdata[PTPC_C_TCLR +: 2];
            t.oc = hwdata[PTPC_C_OC];
            t.pol = hwdata[PTPC_C_POL];
          end
          PTPC_REG_CMPA: t.cmpa = hwdata[15:0] & msk;
          PTPC_REG_CMPB: t.cmpb = hwdata[15:0] & msk;
          PTPC_REG_PER: t.per = hwdata[15:0] & msk;
          PTPC_REG_STAT:
          begin
            // write one to clear; hardware sets below win
            t.flag_a = t.flag_a & ~hwdata[PTPC_S_MATCH_A];
            t.flag_p = t.flag_p & ~hwdata[PTPC_S_MATCH_P];
            t.flag_cap = t.flag_cap & ~hwdata[PTPC_S_CAPTURE];
          end
          default: t.run = t.run;
        endcase
      end

      // two-stage pin synchronisers, third stage for edges
      t.ext_s1 = ext_clk_pin[i];
      t.ext_s2 = cur.ext_s1;
      t.ext_prev = cur.ext_s2;
      t.cap_s1 = capture_pin[i];
      t.cap_s2 = cur.cap_s1;
      t.cap_prev = cur.cap_s2;
      ext_rise = cur.ext_s2 & ~cur.ext_prev;

      // capture source selection, pin read even when driven
      src = cur.capts ? cur.ext_s2 : cur.cap_s2;
      src_prev = cur.capts ? cur.ext_prev : cur.cap_prev;
      src_rise = src & ~src_prev;
      src_fall = ~src & src_prev;

      // period of zero means full counter range
      peff = (cur.per == 16'h0000) ? {1'b0, msk} + 17'h00001 : {1'b0, cur.per};
      pmatch = ({1'b0, cur.cnt} == peff - 17'h00001);
      amatch = (cur.cnt == cur.cmpa);
      rise = cur.run & ~cur.run_prev;
      t.run_prev = cur.run;
      clr = pmatch;
      t.pin = 1'b0;
      t.pin_en = 1'b0;

      case (cur.mode)
        PTPC_MODE_PWM:
        begin
          if (cur.io == PTPC_IO_PULSE)
          begin
            // single pulse: period and cclr unused
            clr = 1'b0;
            if (ext_rise)
              t.run = 1'b1;
            if (cur.run && !rise && amatch)
            begin
              t.run = 1'b0;
              t.flag_a = 1'b1;
            end
            t.pin = (cur.run ? cur.oc : ~cur.oc) ^ cur.pol;
            t.pin_en = 1'b1;
          end
          else
          begin
            // edge-aligned pwm, counting runs in every action
            if (cur.run && !rise && pmatch)
              t.flag_p = 1'b1;
            if (cur.run && !rise && amatch)
              t.flag_a = 1'b1;
            active = cur.run && (({1'b0, cur.cmpa} >= peff) || (cur.cnt < cur.cmpa));
            case (cur.io)
              PTPC_IO_LOW: t.pin = 1'b0;
              PTPC_IO_HIGH: t.pin = 1'b1;
              default: t.pin = (active ? cur.oc : ~cur.oc) ^ cur.pol;
            endcase
            t.pin_en = 1'b1;
          end
        end
        PTPC_MODE_CAP:
        begin
          // edge select picks capture edges
          case (cur.io)
            PTPC_EDGE_RISE: cap_ev = src_rise;
            PTPC_EDGE_FALL: cap_ev = src_fall;
            PTPC_EDGE_BOTH: cap_ev = src_rise | src_fall;
            default: cap_ev = 1'b0;
          endcase
          // clear field adds pin edges to the period clear
          case (cur.tclr)
            PTPC_TCLR_RISE: clr = pmatch | src_rise;
            PTPC_TCLR_FALL: clr = pmatch | src_fall;
            PTPC_TCLR_BOTH: clr = pmatch | src_rise | src_fall;
            default: clr = pmatch;
          endcase
          if (cur.run && !rise && pmatch)
            t.flag_p = 1'b1;
          if (cur.run && cap_ev)
          begin
            t.flag_cap = 1'b1;
            if ((cur.tclr != PTPC_TCLR_PER) && src_fall)
            begin
              t.cmpb = cur.cnt;
              t.vlf = 1'b1;
            end
            else
            begin
              t.cmpa = cur.cnt;
              t.vlf = 1'b0;
            end
          end
          // no output: cclr, oc and pol unused
          t.pin = 1'b0;
          t.pin_en = 1'b0;
        end
        default:
        begin
          // compare and timer modes: plain period counting only
          clr = pmatch;
        end
      endcase

      // common counter: cleared at run rise, counts while run
      if (rise)
        t.cnt = PTPC_RST_VAL;
      else if (cur.run)
        t.cnt = clr ? PTPC_RST_VAL : ((cur.cnt + 16'h0001) & msk);

      nx.tmr[i] = t;
    end

    // address phase: latch writes, prepare read data
    nx.wr_pend = sel & hwrite & (ra < PTPC_MAP_SIZE);
    nx.wr_addr = ra[5:0];
    if (sel && !hwrite && (ra < PTPC_MAP_SIZE))
    begin
      t = nx.tmr[ra[5]];
      case (ra[4:2])
        PTPC_REG_CTRL:
          rd = {21'h000000, t.pol, t.oc, t.tclr, t.capts, t.cclr, t.io, t.mode, t.run};
        PTPC_REG_CMPA: rd = {16'h0000, t.cmpa};
        PTPC_REG_CMPB: rd = {16'h0000, t.cmpb};
        PTPC_REG_PER: rd = {16'h0000, t.per};
        PTPC_REG_CNT: rd = {16'h0000, t.cnt};
        PTPC_REG_STAT: rd = {28'h0000000, t.vlf, t.flag_cap, t.flag_p, t.flag_a};
        default: rd = 32'h0;
      endcase
    end
    nx.rdata = rd;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.ready <= 1'b1;
    end
    else
      st <= nx;
  end

  // outputs straight from flops
  assign hreadyout = st.ready;
  assign hrdata = st.rdata;
  assign hresp = st.resp;

  genvar g;
  generate
    for (g = 0; g < PTPC_NTMR; g++)
    begin : g_out
      assign timer_out[g] = st.tmr[g].pin;
      assign timer_out_en[g] = st.tmr[g].pin_en;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== test/ptpc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptpc_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [1:0]  timer_out,
  input wire logic [1:0]  timer_out_en
);
  logic        wp, rp, prv, pre, arm;
  logic [7:0]  wa;
  logic [15:0] ctl, per;
  logic [16:0] gap;
  wire logic   rise = timer_out[0] & !prv;

  // shadow of timer 0 control and period, gap between output rises
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {wp, rp, prv, pre, arm, wa, ctl, per, gap} <= '0;
    end
    else
    begin
      wp  <= hsel && hready && htrans == 2'h2 && hwrite;
      rp  <= hsel && hready && htrans == 2'h2 && !hwrite;
      wa  <= haddr[7:0];
      prv <= timer_out[0];
      gap <= rise ? 17'h1 : gap + 17'h1;
      if (wp && wa == 8'h00)
        ctl <= hwdata[15:0];
      if (wp && wa == 8'h0C)
        per <= hwdata[15:0];
      // the first period after run rise carries one extra clock, so only
      // a gap that starts at the second or later rise is checked
      pre <= (wp && wa < 8'h20) ? 1'b0 : (rise ? ctl[4:0] == 5'h15 : pre);
      arm <= (wp && wa < 8'h20) ? 1'b0 : (rise ? pre : arm);
    end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
  ready_high_a: assert property (hreadyout == 1'b1) else $error("wait state seen");
  idle_rdata_a: assert property (!rp |-> hrdata == 32'h0) else $error("read data outside read");
  reset_pins_a: assert property ($rose(hresetn) |-> timer_out == 2'h0 && timer_out_en == 2'h0)
    else $error("pins not idle after reset");
  pwm_drive_a: assert property (
    ctl[4:1] == 4'hA && $past(ctl) == ctl && $past(ctl, 2) == ctl |-> timer_out_en[0])
    else $error("pwm output not driven");
  pulse_drive_a: assert property (
    ctl[4:1] == 4'hE && $past(ctl) == ctl && $past(ctl, 2) == ctl |-> timer_out_en[0])
    else $error("pulse output not driven");
  cap_quiet_a: assert property (
    ctl[2:1] == 2'h1 && $past(ctl) == ctl && $past(ctl, 2) == ctl |-> !timer_out_en[0])
    else $error("capture mode drives pin");
  pwm_period_a: assert property (rise && arm && per != 16'h0 |-> gap == {1'b0, per})
    else $error("pwm period wrong");
endmodule
`default_nettype wire

// ==== test/ptpc_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptpc_pins (
  input  wire logic       hclk,
  output var  logic [1:0] ext_clk_pin,
  output var  logic [1:0] capture_pin
);
  // pins idle low until a scenario moves them
  initial
  begin
    ext_clk_pin = 2'h0;
    capture_pin = 2'h0;
  end

  // move one pin after an edge, hold at least two clocks
  task automatic drive(input logic src, input int t, input logic lvl, input int hold);
    @(posedge hclk);
    if (src)
      ext_clk_pin[t] <= lvl;
    else
      capture_pin[t] <= lvl;
    repeat ((hold < 2) ? 2 : hold) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ==== test/periodic_timer_pulse_capture_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_pulse_capture_test;
  import ptpc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, ext_clk_pin, capture_pin, timer_out, timer_out_en;
  logic [2:0]  hsize;
  int          err_total, num_checks, h, p;

  ptpc_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .ext_clk_pin, .capture_pin,
    .timer_out, .timer_out_en);
  ptpc_pins pins (.hclk, .ext_clk_pin, .capture_pin);

  // clock and watchdog
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    print_verdict();
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one single transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  // count high clocks of one output pulse
  task automatic width(input int t, output int n);
    n = 0;
    while (timer_out[t] !== 1'b1) @(posedge hclk);
    while (timer_out[t] === 1'b1)
    begin
      n++;
      @(posedge hclk);
    end
  endtask
  task automatic meas(input int t);
    while (timer_out[t] !== 1'b0) @(posedge hclk);
    // first pulse after run rise is one clock longer, skip it
    width(t, h);
    width(t, h);
    p = h;
    while (timer_out[t] !== 1'b1)
    begin
      p++;
      @(posedge hclk);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // scenarios
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, err_total, num_checks} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({timer_out, timer_out_en}, 0);
    for (int a = 0; a < 64; a += 4)
      rc(8'(a), 0);
    wr(8'h18, 32'hFFFF);
    rc(8'h18, 0);
    wr(8'h40, 32'hFFFF);
    rc(8'h40, 0);
    wr(8'h24, 32'hFFFFFFFF);
    rc(8'h24, 32'h3FF);
    $display("register map test done");
    wr(8'h0C, 8);
    wr(8'h04, 3);
    wr(8'h00, 32'h235);
    meas(0);
    chk(h, 3);
    chk(p, 8);
    wr(8'h04, 8);
    repeat (10) @(posedge hclk);
    h = 0;
    repeat (16)
    begin
      @(posedge hclk);
      h += timer_out[0];
    end
    chk(h, 16);
    wr(8'h00, 32'h20D);
    repeat (3) @(posedge hclk);
    chk(timer_out[0], 1);
    bus(1'b0, 8'h10, 0);
    h = r;
    bus(1'b0, 8'h10, 0);
    chk(r == h, 0);
    wr(8'h24, 1);
    wr(8'h20, 32'h215);
    meas(1);
    chk(p, 1024);
    chk(h, 1);
    $display("pwm test done");
    wr(8'h04, 5);
    wr(8'h00, 32'h21C);
    wr(8'h14, 7);
    fork
      width(0, h);
      pins.drive(1'b1, 0, 1'b1, 4);
    join
    pins.drive(1'b1, 0, 1'b0, 2);
    chk(h >= 6 && h <= 8, 1);
    rc(8'h00, 32'h21C);
    chk(r[0], 1'b0);
    bus(1'b0, 8'h14, 0);
    chk(r[0], 1);
    wr(8'h04, 40);
    fork
      width(0, h);
      begin
        wr(8'h00, 32'h21D);
        repeat (5) @(posedge hclk);
        wr(8'h00, 32'h21C);
      end
    join
    chk(h < 14, 1);
    $display("single pulse test done");
    wr(8'h0C, 0);
    wr(8'h00, 32'h623);
    pins.drive(1'b0, 0, 1'b1, 4);
    bus(1'b0, 8'h14, 0);
    chk(r[3:2], 2'h1);
    bus(1'b0, 8'h04, 0);
    chk(r > 0 && r < 30, 1);
    wr(8'h00, 32'h63B);
    wr(8'h14, 7);
    pins.drive(1'b0, 0, 1'b0, 3);
    pins.drive(1'b0, 0, 1'b1, 3);
    bus(1'b0, 8'h14, 0);
    chk(r[2], 0);
    wr(8'h00, 32'h153);
    pins.drive(1'b1, 0, 1'b1, 4);
    pins.drive(1'b1, 0, 1'b0, 6);
    bus(1'b0, 8'h10, 0);
    chk(r < 10, 1);
    bus(1'b0, 8'h14, 0);
    chk(r[3:2], 2'h3);
    bus(1'b0, 8'h08, 0);
    chk(r != 0, 1);
    $display("capture test done");
    print_verdict();
  end
endmodule

bind ptpc_timer ptpc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .timer_out, .timer_out_en);
`default_nettype wire
